// File: design/lcc_cache_ctrl.v
// Second-level cache control: the supervisor control register, the
// global invalidation sweep and request routing toward cache and bus.
// Assumes the tag lookup datapath supplies tagHit in the request cycle
// and acts on the registered routing outputs one cycle later.
//
// Summary of operation
// - Control register is special-purpose register 1017, supervisor only.
// - Power-on reset clears every bit of the control register.
// - Bit 0 enables the cache; bit 1 enables double-error checkstop.
// - Bit 9 makes instruction requests bypass, with no tag lookup.
// - Setting bit 10 starts a global invalidation of all tags.
// - Bit 12 sends castouts and single-beat stores out to the bus too.
// - Test bit 13 puts block pushes only in cache, marked valid.
// - Test bit drops single-beat stores that miss, unless write-through.
// - Test bit suppresses the bus broadcast of a zero-block op.
// - Bit 31 reads high while invalidation runs; writes ignored.
// - Reserved bits store and read back, with no effect.
// - Cache stays disabled after reset until software enables it.
// - A state machine clears every tag entry one after another.
// - Sweep takes about 32K cycles; busy flag drops at its end.
// - Processor traffic continues normally during an invalidation.
// - Enabled cache: cacheable single reads hit, write hits update.
// - Translation off applies default attributes 0b0011, cacheable.
// - Two-way tags, 2048 entries per way, two sectors each.
`timescale 1ns/1ns
`default_nettype none
`include "lcc_cache_ctrl_regs.vh"

module lcc_cache_ctrl #(
  parameter ENTRIES      = `LCC_TAG_ENTRIES,
  parameter IDX_W        = `LCC_TAG_IDX_W,
  parameter SWEEP_CYCLES = `LCC_SWEEP_CYCLES
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rstn,
  // Special-purpose register port
  input  wire                 sprRead,
  input  wire                 sprWrite,
  input  wire [`LCC_SPR_W-1:0] sprNum,
  input  wire                 supervisor,
  input  wire [31:0]          sprWdata,
  output reg  [31:0]          sprRdata,
  output reg                  sprAck,
  output reg                  privFault,
  // Request from the first-level caches
  input  wire                 reqValid,
  input  wire                 reqInstr,
  input  wire                 reqWrite,
  input  wire                 reqBurst,
  input  wire                 reqPush,
  input  wire                 reqZero,
  input  wire                 xlateOn,
  input  wire [`LCC_ATTR_W-1:0] reqAttr,
  input  wire                 tagHit,
  // Routing decision
  output reg                  tagLookup,
  output reg                  cacheRead,
  output reg                  cacheWrite,
  output reg                  markValid,
  output reg                  markModified,
  output reg                  sectorInval,
  output reg                  busForward,
  output reg                  busBroadcast,
  output reg                  storeDiscard,
  // Error handling
  input  wire                 dblErr,
  output reg                  checkStop,
  // Tag clear strobe and status
  output wire                 tagClrValid,
  output wire [IDX_W-1:0]     tagClrIndex,
  output wire                 tagClrWay,
  output reg                  cacheEnabled
);

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Every entry of every way gets an equal share of the sweep; keep
  // SWEEP_CYCLES at least WAYS * ENTRIES or the step count falls to zero.
  localparam WAYS = `LCC_TAG_WAYS;
  localparam STEP = SWEEP_CYCLES / (WAYS * ENTRIES);

  reg  [31:0] ctrl_reg;
  reg  [31:0] ctrl_next;
  reg         invPrev_reg;
  wire        sweepBusy;
  wire        sprHit;
  wire        sprOk;
  wire        sweepStart;

  assign sprHit = (sprRead || sprWrite) &&
                  sprNum == `LCC_SPR_CACHE_CTRL;
  assign sprOk  = sprHit && supervisor;

  always @* begin
    ctrl_next = ctrl_reg;
    if (sprOk && sprWrite) begin
      // Reserved bits are plain storage; only the busy flag is not stored.
      ctrl_next = sprWdata;
      ctrl_next[`LCC_BIT_BUSY] = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= `LCC_CTRL_RESET;
      invPrev_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      invPrev_reg <= ctrl_reg[`LCC_BIT_INVALIDATE];
    end
  end

  // The sweep is armed again only after software has cleared the bit,
  // so a bit left set across the end of a sweep does not restart it.
  assign sweepStart = ctrl_reg[`LCC_BIT_INVALIDATE] && !invPrev_reg;

  // ****************************************************************
  // Invalidate-in-progress flag
  // ****************************************************************
  // A read right behind the write that sets the invalidate bit is
  // sampled before the sweeper raises busy; counting the start cycle
  // keeps a tight polling loop from taking that read as completion.
  wire readBusy;

  assign readBusy = sweepBusy || sweepStart;

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sprRdata  <= 32'h0000_0000;
      sprAck    <= 1'b0;
      privFault <= 1'b0;
    end else begin
      sprAck    <= sprOk;
      privFault <= sprHit && !supervisor;
      if (sprOk && sprRead) begin
        sprRdata <= ctrl_reg;
        sprRdata[`LCC_BIT_BUSY] <= readBusy;
      end else begin
        sprRdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Global invalidation sweep
  // ****************************************************************
  lcc_inval_sweep #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W),
    .STEP    (STEP)
  ) uSweep (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .start       (sweepStart),
    .busy        (sweepBusy),
    .tagClrValid (tagClrValid),
    .tagClrIndex (tagClrIndex),
    .tagClrWay   (tagClrWay)
  );

  // ****************************************************************
  // Request routing
  // ****************************************************************
  wire                  enBit;
  wire                  dblBit;
  wire                  exclBit;
  wire                  wtBit;
  wire                  testBit;
  wire [`LCC_ATTR_W-1:0] attrEff;
  wire                  cacheable;
  wire                  attrWt;

  assign enBit   = ctrl_reg[`LCC_BIT_ENABLE];
  assign dblBit  = ctrl_reg[`LCC_BIT_DBL_STOP];
  assign exclBit = ctrl_reg[`LCC_BIT_INSTR_EXCL];
  assign wtBit   = ctrl_reg[`LCC_BIT_WRITE_THRU];
  assign testBit = ctrl_reg[`LCC_BIT_TEST_SUPPORT];

  assign attrEff   = xlateOn ? reqAttr : `LCC_ATTR_DEFAULT;
  assign cacheable = !attrEff[`LCC_ATTR_INHIBIT];
  assign attrWt    = attrEff[`LCC_ATTR_WT];

  reg useCache;
  reg lookN;
  reg rdN;
  reg wrN;
  reg validN;
  reg modN;
  reg invN;
  reg busN;
  reg bcastN;
  reg dropN;

  always @* begin
    // A disabled cache passes everything but zero-block ops to the bus, so the core keeps
    // running while the sweep owns the tags.
    useCache = reqValid && enBit && cacheable &&
               !(reqInstr && exclBit);
    lookN  = useCache;
    rdN    = 1'b0;
    wrN    = 1'b0;
    validN = 1'b0;
    modN   = 1'b0;
    invN   = 1'b0;
    busN   = reqValid && !useCache;
    bcastN = 1'b0;
    dropN  = 1'b0;
    if (useCache) begin
      if (reqZero) begin
        // Zero-block: a hit completes locally, a miss is broadcast unless the test bit is set.
        lookN  = 1'b1;
        bcastN = !tagHit && !testBit;
      end else if (reqPush) begin
        if (testBit) begin
          wrN    = 1'b1;
          validN = 1'b1;
        end else begin
          busN = 1'b1;
          invN = tagHit;
        end
      end else if (!reqWrite) begin
        // Reads that hit are served; a burst miss is filled by the reload.
        rdN    = tagHit;
        busN   = !tagHit;
        validN = !tagHit && reqBurst;
      end else if (reqBurst) begin
        // Castout from the first level: written into the cache.
        wrN  = 1'b1;
        modN = !wtBit;
        busN = wtBit;
      end else begin
        // Single-beat store: hits update, never allocate.
        wrN = tagHit;
        if (wtBit || attrWt) begin
          busN = 1'b1;
        end else if (!tagHit) begin
          busN  = !testBit;
          dropN = testBit;
        end
      end
    end else if (reqValid && reqZero) begin
      busN   = 1'b0;
      bcastN = !testBit;
    end
  end

  // ****************************************************************
  // Routing registers
  // ****************************************************************
  // Every decision is registered, so the datapath sees a clean pulse
  // for each request one cycle behind reqValid.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tagLookup    <= 1'b0;
      cacheRead    <= 1'b0;
      cacheWrite   <= 1'b0;
      markValid    <= 1'b0;
      markModified <= 1'b0;
      sectorInval  <= 1'b0;
      busForward   <= 1'b0;
      busBroadcast <= 1'b0;
      storeDiscard <= 1'b0;
      cacheEnabled <= 1'b0;
    end else begin
      tagLookup    <= lookN;
      cacheRead    <= rdN;
      cacheWrite   <= wrN;
      markValid    <= validN;
      markModified <= modN;
      sectorInval  <= invN;
      busForward   <= busN;
      busBroadcast <= bcastN;
      storeDiscard <= dropN;
      cacheEnabled <= enBit;
    end
  end

  // ****************************************************************
  // Double-bit error checkstop
  // ****************************************************************
  // Only a double-bit error seen while the cache is in use stops the core.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      checkStop <= 1'b0;
    end else if (dblErr && dblBit && enBit) begin
      // Sticky until reset: the core has to be restarted to recover.
      checkStop <= 1'b1;
    end
  end

endmodule // lcc_cache_ctrl

`default_nettype wire

// File: design/lcc_cache_ctrl_regs.vh
// Constants for the second-level cache control block: the special-purpose
// register number, control register bit positions, reset value and the
// default memory attribute bits. Assumes inclusion by bare name.
`ifndef LCC_CACHE_CTRL_REGS_VH
`define LCC_CACHE_CTRL_REGS_VH

// ****************************************************************
// Register access
// ****************************************************************
`define LCC_SPR_W             10
`define LCC_SPR_CACHE_CTRL    10'h3f9
`define LCC_CTRL_RESET        32'h0000_0000

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define LCC_BIT_ENABLE        0
`define LCC_BIT_DBL_STOP      1
`define LCC_BIT_INSTR_EXCL    9
`define LCC_BIT_INVALIDATE    10
`define LCC_BIT_WRITE_THRU    12
`define LCC_BIT_TEST_SUPPORT  13
`define LCC_BIT_BUSY          31

// ****************************************************************
// Memory attribute bits (write-through, inhibit, coherent, guarded)
// ****************************************************************
`define LCC_ATTR_W            4
`define LCC_ATTR_WT           3
`define LCC_ATTR_INHIBIT      2
`define LCC_ATTR_DEFAULT      4'h3

// ****************************************************************
// Tag array geometry and sweep length
// ****************************************************************
`define LCC_TAG_ENTRIES       2048
`define LCC_TAG_IDX_W         11
`define LCC_TAG_WAYS          2
`define LCC_SWEEP_CYCLES      32768

`endif

// File: design/lcc_inval_sweep.v
// Global invalidation sweeper: walks every tag entry of every way and
// issues a clear strobe for each. Assumes the tag datapath clears tag,
// status and replacement bits of the addressed entry on tagClrValid.
`timescale 1ns/1ns
`default_nettype none
`include "lcc_cache_ctrl_regs.vh"

module lcc_inval_sweep #(
  parameter ENTRIES = `LCC_TAG_ENTRIES,
  parameter IDX_W   = `LCC_TAG_IDX_W,
  parameter STEP    = 8
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rstn,
  // Control
  input  wire             start,
  output reg              busy,
  // Tag clear strobe
  output reg              tagClrValid,
  output reg  [IDX_W-1:0] tagClrIndex,
  output reg              tagClrWay
);

  // ****************************************************************
  // Sweep counters
  // ****************************************************************
  localparam integer     LAST_IDX_I  = ENTRIES - 1;
  localparam integer     LAST_STEP_I = STEP - 1;
  localparam [IDX_W-1:0] LAST_IDX    = LAST_IDX_I[IDX_W-1:0];
  localparam [15:0]      LAST_STEP   = LAST_STEP_I[15:0];

  reg [15:0] stepCnt;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy        <= 1'b0;
      tagClrValid <= 1'b0;
      tagClrIndex <= {IDX_W{1'b0}};
      tagClrWay   <= 1'b0;
      stepCnt     <= 16'h0000;
    end else if (!busy) begin
      tagClrValid <= 1'b0;
      if (start) begin
        // One entry is cleared every STEP cycles, both ways in turn.
        busy        <= 1'b1;
        tagClrValid <= 1'b1;
        tagClrIndex <= {IDX_W{1'b0}};
        tagClrWay   <= 1'b0;
        stepCnt     <= 16'h0000;
      end
    end else if (stepCnt != LAST_STEP) begin
      stepCnt     <= stepCnt + 16'h0001;
      tagClrValid <= 1'b0;
    end else begin
      stepCnt <= 16'h0000;
      if (tagClrWay && tagClrIndex == LAST_IDX) begin
        busy        <= 1'b0;
        tagClrValid <= 1'b0;
      end else begin
        tagClrValid <= 1'b1;
        tagClrWay   <= ~tagClrWay;
        if (tagClrWay) begin
          tagClrIndex <= tagClrIndex + {{(IDX_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // lcc_inval_sweep

`default_nettype wire

// File: dv/lcc_tag_model.sv
// Far-side tag array stand-in: one valid bit per entry and way.
// Assumes the bench fills it and the sweep strobe empties it.
`timescale 1ns/1ns
`default_nettype none
module lcc_tag_model #(
  parameter ENTRIES = 8,
  parameter IDX_W   = 3
) (
  // Clock
  input  wire logic                 clk_sys,
  // Bench side
  input  wire logic                 fillAll,
  input  wire logic [IDX_W:0]       lookSlot,
  output wire logic                 tagHit,
  output var  logic [2*ENTRIES-1:0] validMap,
  // Clear strobe
  input  wire logic                 tagClrValid,
  input  wire logic [IDX_W-1:0]     tagClrIndex,
  input  wire logic                 tagClrWay
);
  // Two ways per entry, so a slot is the entry index with the way below.
  assign tagHit = validMap[lookSlot];
  always @(posedge clk_sys) begin
    if (fillAll)
      validMap <= '1;
    else if (tagClrValid)
      validMap[{tagClrIndex, tagClrWay}] <= 1'b0;
  end
endmodule // lcc_tag_model
`default_nettype wire

// File: dv/lcc_cache_ctrl_props.sv
// Checker for the second-level cache control block, bound onto its top.
// Assumes the register header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "lcc_cache_ctrl_regs.vh"
module lcc_cache_ctrl_props #(
  parameter ENTRIES      = 8,
  parameter SWEEP_CYCLES = 128
) (
  // Clock, reset and register port
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        sprRead,
  input wire logic        sprWrite,
  input wire logic [9:0]  sprNum,
  input wire logic        supervisor,
  input wire logic [31:0] sprWdata,
  input wire logic        sprAck,
  input wire logic        privFault,
  // Requests and routing
  input wire logic        reqValid,
  input wire logic        reqInstr,
  input wire logic        reqWrite,
  input wire logic        reqBurst,
  input wire logic        reqPush,
  input wire logic        reqZero,
  input wire logic        xlateOn,
  input wire logic        tagHit,
  input wire logic        cacheWrite,
  input wire logic        markValid,
  input wire logic        busForward,
  input wire logic        busBroadcast,
  input wire logic        storeDiscard,
  // Sweep and status
  input wire logic        tagClrValid,
  input wire logic        cacheEnabled
);
  localparam LAST = 2 * ENTRIES - 1;
  localparam logic [15:0] GAP = 16'(SWEEP_CYCLES / (2 * ENTRIES) - 1);
  // Cycles since the last clear strobe, saturating.
  logic [15:0] gapCnt;
  // Shadow of the written control word; the busy bit is kept as written, not forced to zero.
  logic [31:0] shadowReg;
  logic [7:0]  clrCnt;
  wire acc = (sprRead || sprWrite) && sprNum == `LCC_SPR_CACHE_CTRL;
  wire take = sprWrite && acc && supervisor;
  wire opn = reqValid && !reqInstr && !xlateOn && shadowReg[0];
  wire single = reqWrite && !reqBurst && !reqPush && !reqZero;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shadowReg <= 32'h0;
      clrCnt    <= 8'h0;
      gapCnt    <= 16'h0;
    end else begin
      if (tagClrValid)
        gapCnt <= 16'h0;
      else if (gapCnt != 16'hffff)
        gapCnt <= gapCnt + 16'h1;
      if (take)
        shadowReg <= sprWdata;
      if (tagClrValid)
        clrCnt <= (clrCnt == LAST) ? 8'h0 : clrCnt + 8'h1;
    end
  end
  // *****
  // Assertions
  // *****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_ack; acc && supervisor |=> sprAck; endproperty
  a_ack: assert property (p_ack)
    else $error("access not acknowledged");
  property p_flt; acc && !supervisor |=> privFault && !sprAck; endproperty
  a_flt: assert property (p_flt)
    else $error("user access not refused");
  property p_en; take ##1 !take |=> cacheEnabled == shadowReg[0]; endproperty
  a_en: assert property (p_en)
    else $error("enable does not follow bit 0");
  property p_go; take && sprWdata[10] && !shadowReg[10] && clrCnt == 8'h0
    |-> ##[1:12] tagClrValid; endproperty
  a_go: assert property (p_go)
    else $error("sweep did not start");
  property p_gap; tagClrValid |-> gapCnt >= GAP; endproperty
  a_gap: assert property (p_gap)
    else $error("clear strobes too close");
  property p_disc; opn && single && !tagHit && shadowReg[13] &&
    !shadowReg[12] |=> storeDiscard && !busForward; endproperty
  a_disc: assert property (p_disc)
    else $error("missing store not dropped");
  property p_push; opn && reqPush && shadowReg[13]
    |=> cacheWrite && markValid && !busForward; endproperty
  a_push: assert property (p_push)
    else $error("test push not kept in cache");
  property p_zero; reqValid && reqZero && shadowReg[13] |=> !busBroadcast;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero-block broadcast not suppressed");
  c_sweep: cover property (tagClrValid && clrCnt == LAST);
  c_disc: cover property (storeDiscard);
  c_push: cover property (cacheWrite && markValid);
endmodule // lcc_cache_ctrl_props
bind lcc_cache_ctrl lcc_cache_ctrl_props #(.ENTRIES(ENTRIES),
  .SWEEP_CYCLES(SWEEP_CYCLES)) i_props (
  .clk_sys(clk_sys), .rstn(rstn), .sprRead(sprRead), .sprWrite(sprWrite),
  .sprNum(sprNum), .supervisor(supervisor), .sprWdata(sprWdata),
  .sprAck(sprAck), .privFault(privFault), .reqValid(reqValid),
  .reqInstr(reqInstr), .reqWrite(reqWrite), .reqBurst(reqBurst),
  .reqPush(reqPush), .reqZero(reqZero), .xlateOn(xlateOn),
  .tagHit(tagHit), .cacheWrite(cacheWrite), .markValid(markValid),
  .busForward(busForward), .busBroadcast(busBroadcast),
  .storeDiscard(storeDiscard), .tagClrValid(tagClrValid),
  .cacheEnabled(cacheEnabled));
`default_nettype wire

// File: dv/test_l2_cache_control_invalidate.sv
// Self-checking bench for the second-level cache control block.
// Assumes the design, its header and the tag model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "lcc_cache_ctrl_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_l2_cache_control_invalidate;
  localparam logic [9:0] CTL = `LCC_SPR_CACHE_CTRL;
  logic        clk_sys, rstn, sprRead, sprWrite, supervisor, reqValid;
  logic        reqInstr, reqWrite, reqBurst, reqPush, reqZero, xlateOn;
  logic        dblErr, fillAll, tagHit, sprAck, privFault, tagLookup;
  logic        cacheRead, cacheWrite, markValid, markModified, sectorInval;
  logic        busForward, busBroadcast, storeDiscard, checkStop;
  logic        tagClrValid, tagClrWay, cacheEnabled, ack, flt;
  logic [9:0]  sprNum;
  logic [31:0] sprWdata, sprRdata, rd;
  logic [3:0]  reqAttr, lookSlot;
  logic [2:0]  tagClrIndex;
  logic [15:0] validMap;
  int          checks = 0, bad_count = 0, strobeCnt = 0, n;
  // Short sweep: 8 entries a way, 64 cycles in all, keeps the run brief.
  lcc_cache_ctrl #(.ENTRIES(8), .IDX_W(3), .SWEEP_CYCLES(64)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .sprRead(sprRead),
    .sprWrite(sprWrite), .sprNum(sprNum), .supervisor(supervisor),
    .sprWdata(sprWdata), .sprRdata(sprRdata), .sprAck(sprAck),
    .privFault(privFault), .reqValid(reqValid), .reqInstr(reqInstr),
    .reqWrite(reqWrite), .reqBurst(reqBurst), .reqPush(reqPush),
    .reqZero(reqZero), .xlateOn(xlateOn), .reqAttr(reqAttr),
    .tagHit(tagHit), .tagLookup(tagLookup), .cacheRead(cacheRead),
    .cacheWrite(cacheWrite), .markValid(markValid),
    .markModified(markModified), .sectorInval(sectorInval),
    .busForward(busForward), .busBroadcast(busBroadcast),
    .storeDiscard(storeDiscard), .dblErr(dblErr), .checkStop(checkStop),
    .tagClrValid(tagClrValid), .tagClrIndex(tagClrIndex),
    .tagClrWay(tagClrWay), .cacheEnabled(cacheEnabled));
  lcc_tag_model i_tags (.clk_sys(clk_sys), .fillAll(fillAll),
    .lookSlot(lookSlot), .tagHit(tagHit), .validMap(validMap),
    .tagClrValid(tagClrValid), .tagClrIndex(tagClrIndex),
    .tagClrWay(tagClrWay));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (tagClrValid === 1'b1) begin
      `CHK("slot", strobeCnt[3:0], {tagClrIndex, tagClrWay})
      strobeCnt++;
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task spr(input logic w, input logic [9:0] num, input logic s,
           input logic [31:0] d);
    {sprWrite, sprRead, sprNum, supervisor, sprWdata} = {w, ~w, num, s, d};
    @(negedge clk_sys);
    {rd, ack, flt} = {sprRdata, sprAck, privFault};
    {sprWrite, sprRead} = 2'b00;
    @(negedge clk_sys);
  endtask
  // Polls the busy bit back to back, as a tight software loop would.
  task sweep(input logic [31:0] c);
    spr(1'b1, CTL, 1'b1, c);
    n = 0;
    rd = 32'hffff_ffff;
    while (rd[31] === 1'b1 && n < 200) begin
      spr(1'b0, CTL, 1'b1, 32'h0);
      n++;
    end
  endtask
  task rq(input logic [5:0] k, input logic [3:0] a, input logic [8:0] e);
    {reqInstr, reqWrite, reqBurst, reqPush, reqZero, xlateOn} = k;
    {reqAttr, reqValid} = {a, 1'b1};
    @(negedge clk_sys);
    `CHK("route", e, {tagLookup, cacheRead, cacheWrite, markValid,
      markModified, sectorInval, busForward, busBroadcast, storeDiscard})
    reqValid = 1'b0;
    @(negedge clk_sys);
  endtask
  // Strobes the fill line of the tag model, or the double-error input.
  task pulse(input logic err);
    {dblErr, fillAll} = {err, ~err};
    @(negedge clk_sys);
    {dblErr, fillAll} = 2'b00;
    @(negedge clk_sys);
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  // *****
  // Tests
  // *****
  initial begin
    {sprRead, sprWrite, supervisor, reqValid, reqInstr, reqWrite, reqBurst,
      reqPush, reqZero, xlateOn, dblErr, fillAll, sprNum, sprWdata, reqAttr,
      lookSlot} = '0;
    rstn = 1'b0;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    spr(1'b0, CTL, 1'b1, 32'h0);
    `CHK("reset", 32'h0, rd)
    `CHK("enOff", 1'b0, cacheEnabled)
    spr(1'b1, CTL, 1'b1, 32'hffff_c9fc);
    spr(1'b0, CTL, 1'b1, 32'h0);
    `CHK("resv", 32'h7fff_c9fc, rd)
    spr(1'b1, CTL, 1'b0, 32'h0);
    `CHK("fault", 2'b01, {ack, flt})
    spr(1'b0, CTL - 10'h1, 1'b1, 32'h0);
    `CHK("otherNum", 1'b0, ack)
    spr(1'b0, CTL, 1'b1, 32'h0);
    `CHK("kept", 32'h7fff_c9fc, rd)
    spr(1'b1, CTL, 1'b1, 32'h0);
    $display("test register access done");
    pulse(1'b0);
    sweep(32'h400);
    `CHK("busyLen", 1'b1, n > 28 && n < 38)
    `CHK("swept", 16, strobeCnt)
    `CHK("cleared", 16'h0, validMap)
    sweep(32'h400);
    repeat (12) @(negedge clk_sys);
    `CHK("noRestart", 16, strobeCnt)
    spr(1'b1, CTL, 1'b1, 32'h0);
    spr(1'b1, CTL, 1'b1, 32'h400);
    rq(6'h00, 4'h0, 9'h004);
    sweep(32'h400);
    `CHK("restart", 32, strobeCnt)
    spr(1'b1, CTL, 1'b1, 32'h0);
    spr(1'b1, CTL, 1'b1, 32'h2001);
    `CHK("enOn", 1'b1, cacheEnabled)
    $display("test invalidation done");
    rq(6'h10, 4'h0, 9'h101);
    rq(6'h02, 4'h0, 9'h100);
    rq(6'h04, 4'h0, 9'h160);
    spr(1'b1, CTL, 1'b1, 32'h1);
    rq(6'h10, 4'h0, 9'h104);
    rq(6'h02, 4'h0, 9'h102);
    pulse(1'b0);
    rq(6'h01, 4'h0, 9'h180);
    rq(6'h00, 4'h4, 9'h180);
    rq(6'h01, 4'h4, 9'h004);
    rq(6'h10, 4'h0, 9'h140);
    rq(6'h04, 4'h0, 9'h10c);
    rq(6'h18, 4'h0, 9'h150);
    spr(1'b1, CTL, 1'b1, 32'h201);
    rq(6'h20, 4'h0, 9'h004);
    spr(1'b1, CTL, 1'b1, 32'h1001);
    rq(6'h10, 4'h0, 9'h144);
    spr(1'b1, CTL, 1'b1, 32'h0);
    rq(6'h00, 4'h0, 9'h004);
    $display("test routing done");
    spr(1'b1, CTL, 1'b1, 32'h1);
    pulse(1'b1);
    `CHK("noStop", 1'b0, checkStop)
    spr(1'b1, CTL, 1'b1, 32'h3);
    pulse(1'b1);
    `CHK("stop", 1'b1, checkStop)
    $display("test double error done");
    stop_test;
  end
endmodule // test_l2_cache_control_invalidate
`default_nettype wire
